// [tb.sv]
// Self-checking bench for the wide timer core: register table, wide access, timer events.
// Assumes the processor model drives the register bus and this bench drives the timer pins.
module tb import wtb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FT = 16'h00ff;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
  } wtb_row_t;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'h1;
  logic [1:0]        s_axi_bresp, s_axi_rresp, compare_output_pins;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic              external_count_pin = 1'b0, capture_input_pin = 1'b0, comparator_output = 1'b0;
  logic [3:0]        timer_requests;
  logic [7:0]        q;
  logic [15:0]       v, v2;
  int                miscompares = 0, n_checks = 0, cyc = 0;
  wtb_row_t rows [10] = '{'{OFS_CTRL_C, 8'h5a, 8'h5a, RESP_OKAY}, '{OFS_MASK, 8'h0f, 8'h0f, RESP_OKAY},
    '{OFS_CTRL_A, 8'h07, 8'h07, RESP_OKAY}, '{OFS_CTRL_A, 8'h00, 8'h00, RESP_OKAY},
    '{OFS_CTRL_B, 8'h3f, 8'h3f, RESP_OKAY}, '{OFS_CTRL_B, 8'h00, 8'h00, RESP_OKAY},
    '{OFS_MASK, 8'h00, 8'h00, RESP_OKAY}, '{OFS_POWER, 8'h01, 8'h01, RESP_OKAY},
    '{OFS_POWER, 8'h00, 8'h00, RESP_OKAY}, '{8'h38, 8'hff, 8'h00, RESP_SLVERR}};
  always #10 aclk = ~aclk;
  wtb_core #(.FIXED_TOP(FT)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_count_pin, .capture_input_pin, .comparator_output, .compare_output_pins, .timer_requests);
  wtb_cpu cpu (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata, .s_axi_wvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .s_axi_rresp);
  // ----
  // Helpers
  // ----
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] x;
    cpu.acc(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] x;
    cpu.acc(1'b0, a, 8'h00, x);
    chk({8'h00, x}, {8'h00, e});
  endtask
  task automatic wait_req(input int i);
    int n;
    n = 0;
    while (timer_requests[i] !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk({15'h0, timer_requests[i]}, 16'h0001);
  endtask
  // The whole run needs under a thousand cycles; a hang stops well short of the overall budget.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(OFS_POWER, 8'h00);
    foreach (rows[i]) begin
      cpu.acc(1'b1, rows[i].a, rows[i].d, q);
      cpu.acc(1'b0, rows[i].a, 8'h00, q);
      chk({8'h00, q}, {8'h00, rows[i].q});
      chk({14'h0, cpu.resp}, {14'h0, rows[i].r});
    end
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 56; a += 4) rc(8'(a), 8'h00);
    cpu.wr16(OFS_CNT_L, OFS_CNT_H, 16'h1234);
    cpu.rd16(OFS_CNT_L, OFS_CNT_H, v);
    chk(v, 16'h1234);
    wr(OFS_CNT_H, 8'hab);
    rc(OFS_CNT_H, 8'hab);
    rc(OFS_CNT_L, 8'h34);
    rc(OFS_CNT_H, 8'h12);
    cpu.wr16(OFS_CMPA_L, OFS_CMPA_H, 16'h5678);
    wr(OFS_CNT_H, 8'h99);
    rc(OFS_CMPA_H, 8'h56);
    rc(OFS_CMPA_L, 8'h78);
    rc(OFS_CNT_H, 8'h99);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL_A, k ? {6'h0, TOP_CAP} : 8'h00);
      cpu.wr16(OFS_CAP_L, OFS_CAP_H, 16'h4321);
      cpu.rd16(OFS_CAP_L, OFS_CAP_H, v);
      chk(v, k ? 16'h4321 : 16'h0000);
    end
    wr(OFS_CTRL_A, 8'h00);
    cpu.wr16(OFS_CNT_L, OFS_CNT_H, 16'h0abc);
    wr(OFS_MASK, 8'h08);
    wr(OFS_CTRL_B, 8'h08);
    capture_input_pin <= 1'b1;
    wait_req(3);
    cpu.rd16(OFS_CAP_L, OFS_CAP_H, v);
    chk(v, 16'h0abc);
    wr(OFS_FLAG, 8'h08);
    rc(OFS_FLAG, 8'h00);
    foreach (rows[k]) if (k < 2) begin
      wr(OFS_CTRL_B, k ? {5'h0, CS_EXT_FALL} : {5'h0, CS_EXT_RISE});
      repeat (3) begin
        external_count_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        external_count_pin <= 1'b0;
        repeat (4) @(posedge aclk);
      end
    end
    wr(OFS_CTRL_B, 8'h00);
    cpu.rd16(OFS_CNT_L, OFS_CNT_H, v);
    chk(v, 16'h0ac2);
    wr(OFS_CTRL_B, {5'h0, CS_DIV});
    repeat (80) @(posedge aclk);
    wr(OFS_CTRL_B, 8'h00);
    cpu.rd16(OFS_CNT_L, OFS_CNT_H, v);
    chk({15'h0, v > 16'h0ac2 && v < 16'h0ae2}, 16'h0001);
    wr(OFS_MASK, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_FLAG, 8'h0f);
      wr(OFS_CTRL_A, k ? {6'h0, TOP_FIXED} : 8'h00);
      cpu.wr16(OFS_CNT_L, OFS_CNT_H, k ? FT - 16'h0008 : CNT_MAX - 16'h000f);
      wr(OFS_CTRL_B, {5'h0, CS_SYS});
      wait_req(0);
      wr(OFS_CTRL_B, 8'h00);
      cpu.rd16(OFS_CNT_L, OFS_CNT_H, v);
      chk({15'h0, v < 16'h0040}, 16'h0001);
    end
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_FLAG, 8'h0f);
    cpu.wr16(OFS_CNT_L, OFS_CNT_H, 16'h0000);
    cpu.wr16(OFS_CMPA_L, OFS_CMPA_H, 16'h0040);
    wr(OFS_MASK, 8'h02);
    wr(OFS_CTRL_B, {5'h0, CS_SYS});
    wait_req(1);
    @(negedge aclk);
    chk({14'h0, compare_output_pins}, 16'h0003);
    chk({12'h0, timer_requests}, 16'h0002);
    @(posedge aclk);
    rc(OFS_FLAG, 8'h06);
    wr(OFS_POWER, 8'h01);
    cpu.rd16(OFS_CNT_L, OFS_CNT_H, v);
    repeat (20) @(posedge aclk);
    cpu.rd16(OFS_CNT_L, OFS_CNT_H, v2);
    chk(v2, v);
    wr(OFS_POWER, 8'h00);
    wr(OFS_CTRL_A, {6'h01, TOP_CMPA});
    repeat (4) begin
      repeat (37) @(negedge aclk);
      chk({15'h0, compare_output_pins[0]}, 16'h0000);
    end
    finish_test();
  end
endmodule

// [wtb_core.sv]
// Wide timer core with an 8-bit register file behind an AXI4-Lite slave.
// Assumes pins are synchronous to aclk and the master keeps one write and one read in flight.
module wtb_core import wtb_pkg::*; #(
  parameter int unsigned PRESC_DIV = 8,
  parameter logic [15:0] FIXED_TOP = 16'h00ff
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Timer pins
  input  wire logic              external_count_pin,
  input  wire logic              capture_input_pin,
  input  wire logic              comparator_output,
  output logic [1:0]             compare_output_pins,
  output logic [3:0]             timer_requests
);
  if (PRESC_DIV < 2 || PRESC_DIV > 65536) begin : g_div_check
    $error("PRESC_DIV out of range");
  end
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wtb_ctla_t        ctl_a, next_ctl_a;
  wtb_ctlb_t        ctl_b, next_ctl_b;
  logic [7:0]       ctl_c, next_ctl_c;
  logic [3:0]       flag, next_flag;
  logic [3:0]       mask, next_mask;
  logic             power_off, next_power_off;
  logic [7:0]       temp, next_temp;
  logic [15:0]      cnt, next_cnt;
  logic [15:0]      cmpa_buf, next_cmpa_buf;
  logic [15:0]      cmpa_act, next_cmpa_act;
  logic [15:0]      cmpb_buf, next_cmpb_buf;
  logic [15:0]      cmpb_act, next_cmpb_act;
  logic [15:0]      cap, next_cap;
  logic [1:0]       outs, next_outs;
  logic [15:0]      presc, next_presc;
  logic             ext_prev, next_ext_prev;
  logic [3:0]       filt, next_filt;
  logic             filt_out, next_filt_out;
  logic             cap_prev, next_cap_prev;
  logic             aw_held, next_aw_held;
  logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic             w_held, next_w_held;
  logic [7:0]       wdata_q, next_wdata_q;
  logic             wlane_q, next_wlane_q;
  logic             bvalid, next_bvalid;
  logic [1:0]       bresp, next_bresp;
  wtb_rd_t          rstate, next_rstate;
  logic [31:0]      rdata, next_rdata;
  logic [1:0]       rresp, next_rresp;
  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic        do_wr, do_rd, tick, at_top, at_bottom, cap_en, cap_src_lvl, cap_ev;
  logic [15:0] top_val;
  logic [7:0]  wd, rbyte;
  logic [3:0]  flag_set, flag_clr;
  logic        rd_err, wr_err;
  localparam logic [15:0] PRESC_LAST = 16'(PRESC_DIV - 1);
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = (rstate == WTB_RD_IDLE);
  assign s_axi_rvalid  = (rstate == WTB_RD_BUSY);
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign compare_output_pins = outs;
  assign timer_requests = flag & mask;
  always_comb begin
    next_ctl_a = ctl_a;
    next_ctl_b = ctl_b;
    next_ctl_c = ctl_c;
    next_mask = mask;
    next_power_off = power_off;
    next_temp = temp;
    next_cnt = cnt;
    next_cmpa_buf = cmpa_buf;
    next_cmpa_act = cmpa_act;
    next_cmpb_buf = cmpb_buf;
    next_cmpb_act = cmpb_act;
    next_cap = cap;
    next_outs = outs;
    next_presc = presc;
    next_aw_held = aw_held;
    next_awaddr_q = awaddr_q;
    next_w_held = w_held;
    next_wdata_q = wdata_q;
    next_wlane_q = wlane_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rstate = rstate;
    next_rdata = rdata;
    next_rresp = rresp;
    flag_set = 4'h0;
    flag_clr = 4'h0;
    rbyte = 8'h00;
    rd_err = 1'b0;
    wr_err = 1'b0;
    wd = wdata_q;
    // ----------------------------------------------------------------
    // Timer clock and limits
    // ----------------------------------------------------------------
    next_ext_prev = external_count_pin;
    if (presc == PRESC_LAST || power_off) begin
      next_presc = 16'h0000;
    end else begin
      next_presc = presc + 16'h0001;
    end
    unique case (ctl_b.clk_sel)
      CS_SYS:      tick = 1'b1;
      CS_DIV:      tick = (presc == PRESC_LAST);
      CS_EXT_FALL: tick = ext_prev && !external_count_pin;
      CS_EXT_RISE: tick = !ext_prev && external_count_pin;
      default:     tick = 1'b0;
    endcase
    tick = tick && !power_off;
    unique case (ctl_a.top_sel)
      TOP_CMPA:  top_val = cmpa_act;
      TOP_CAP:   top_val = cap;
      TOP_FIXED: top_val = FIXED_TOP;
      default:   top_val = CNT_MAX;
    endcase
    at_top = (cnt == top_val);
    at_bottom = (cnt == CNT_BOTTOM);
    if (tick) begin
      if (at_top) begin
        next_cnt = CNT_BOTTOM;
        flag_set[FLG_OVF] = 1'b1;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
    // Pulse-width mode loads new compare values only at bottom, so a period is never torn.
    if (!ctl_a.pwm || (tick && at_bottom)) begin
      next_cmpa_act = cmpa_buf;
      next_cmpb_act = cmpb_buf;
    end
    // ----------------------------------------------------------------
    // Compare channels
    // ----------------------------------------------------------------
    if (tick && cnt == cmpa_act) begin
      flag_set[FLG_CMPA] = 1'b1;
      if (!ctl_a.pwm) begin
        next_outs[0] = !outs[0];
      end
    end
    if (tick && cnt == cmpb_act) begin
      flag_set[FLG_CMPB] = 1'b1;
      if (!ctl_a.pwm) begin
        next_outs[1] = !outs[1];
      end
    end
    if (ctl_a.pwm) begin
      next_outs[1] = (next_cnt < cmpb_act);
      if (ctl_a.top_sel == TOP_CMPA) begin
        next_outs[0] = 1'b0;
      end else begin
        next_outs[0] = (next_cnt < cmpa_act);
      end
    end
    // ----------------------------------------------------------------
    // Capture input
    // ----------------------------------------------------------------
    cap_src_lvl = ctl_b.cap_src ? comparator_output : capture_input_pin;
    next_filt = {filt[2:0], cap_src_lvl};
    next_filt_out = filt_out;
    if (!ctl_b.noise_en) begin
      next_filt_out = cap_src_lvl;
    end else if (filt == 4'hf || filt == 4'h0) begin
      next_filt_out = filt[3];
    end
    next_cap_prev = filt_out;
    cap_en = !power_off && ctl_a.top_sel != TOP_CAP;
    cap_ev = ctl_b.cap_rise ? (filt_out && !cap_prev) : (!filt_out && cap_prev);
    if (cap_en && cap_ev) begin
      next_cap = cnt;
      flag_set[FLG_CAP] = 1'b1;
    end
    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    do_rd = s_axi_arvalid && rstate == WTB_RD_IDLE;
    if (do_rd) begin
      unique case (s_axi_araddr)
        OFS_CTRL_A: rbyte = ctl_a;
        OFS_CTRL_B: rbyte = ctl_b;
        OFS_CTRL_C: rbyte = ctl_c;
        OFS_FLAG:   rbyte = {4'h0, flag};
        OFS_MASK:   rbyte = {4'h0, mask};
        OFS_POWER:  rbyte = {7'h00, power_off};
        OFS_CNT_L: begin
          rbyte = cnt[7:0];
          next_temp = cnt[15:8];
        end
        OFS_CAP_L: begin
          rbyte = cap[7:0];
          next_temp = cap[15:8];
        end
        OFS_CNT_H:  rbyte = temp;
        OFS_CAP_H:  rbyte = temp;
        OFS_CMPA_L: rbyte = cmpa_buf[7:0];
        OFS_CMPA_H: rbyte = cmpa_buf[15:8];
        OFS_CMPB_L: rbyte = cmpb_buf[7:0];
        OFS_CMPB_H: rbyte = cmpb_buf[15:8];
        default:    rd_err = 1'b1;
      endcase
      next_rdata = {24'h000000, rbyte};
      next_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
      next_rstate = WTB_RD_BUSY;
    end else if (rstate == WTB_RD_BUSY && s_axi_rready) begin
      next_rstate = WTB_RD_IDLE;
    end
    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata[7:0];
      next_wlane_q = s_axi_wstrb[0];
    end
    do_wr = aw_held && w_held && !bvalid;
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (awaddr_q)
        OFS_CTRL_A, OFS_CTRL_B, OFS_CTRL_C, OFS_FLAG, OFS_MASK, OFS_POWER,
        OFS_CNT_L, OFS_CNT_H, OFS_CMPA_L, OFS_CMPA_H, OFS_CMPB_L, OFS_CMPB_H,
        OFS_CAP_L, OFS_CAP_H: wr_err = 1'b0;
        default:              wr_err = 1'b1;
      endcase
      next_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
      if (wlane_q) begin
        unique case (awaddr_q)
          OFS_CTRL_A: next_ctl_a = wtb_ctla_t'({5'h00, wd[2:0]});
          OFS_CTRL_B: next_ctl_b = wtb_ctlb_t'({2'h0, wd[5:0]});
          OFS_CTRL_C: next_ctl_c = wd;
          OFS_FLAG:   flag_clr = wd[3:0];
          OFS_MASK:   next_mask = wd[3:0];
          OFS_POWER:  next_power_off = wd[0];
          OFS_CNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H: begin
            next_temp = wd;
          end
          OFS_CNT_L:  next_cnt = {temp, wd};
          OFS_CMPA_L: next_cmpa_buf = {temp, wd};
          OFS_CMPB_L: next_cmpb_buf = {temp, wd};
          OFS_CAP_L: begin
            if (ctl_a.top_sel == TOP_CAP) begin
              next_cap = {temp, wd};
            end
          end
          default: wr_err = 1'b1;
        endcase
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // A hardware event in the clearing cycle survives the write of one.
    next_flag = (flag & ~flag_clr) | flag_set;
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_a <= wtb_ctla_t'(CTRL_RESET);
      ctl_b <= wtb_ctlb_t'(CTRL_RESET);
      ctl_c <= CTRL_RESET;
      flag <= 4'h0;
      mask <= 4'h0;
      power_off <= 1'b0;
      temp <= 8'h00;
      cnt <= CNT_BOTTOM;
      cmpa_buf <= 16'h0000;
      cmpa_act <= 16'h0000;
      cmpb_buf <= 16'h0000;
      cmpb_act <= 16'h0000;
      cap <= 16'h0000;
      outs <= 2'h0;
      presc <= 16'h0000;
      ext_prev <= 1'b0;
      filt <= 4'h0;
      filt_out <= 1'b0;
      cap_prev <= 1'b0;
      aw_held <= 1'b0;
      awaddr_q <= '0;
      w_held <= 1'b0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rstate <= WTB_RD_IDLE;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      ctl_a <= next_ctl_a;
      ctl_b <= next_ctl_b;
      ctl_c <= next_ctl_c;
      flag <= next_flag;
      mask <= next_mask;
      power_off <= next_power_off;
      temp <= next_temp;
      cnt <= next_cnt;
      cmpa_buf <= next_cmpa_buf;
      cmpa_act <= next_cmpa_act;
      cmpb_buf <= next_cmpb_buf;
      cmpb_act <= next_cmpb_act;
      cap <= next_cap;
      outs <= next_outs;
      presc <= next_presc;
      ext_prev <= next_ext_prev;
      filt <= next_filt;
      filt_out <= next_filt_out;
      cap_prev <= next_cap_prev;
      aw_held <= next_aw_held;
      awaddr_q <= next_awaddr_q;
      w_held <= next_w_held;
      wdata_q <= next_wdata_q;
      wlane_q <= next_wlane_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rstate <= next_rstate;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule

// [wtb_core_props.sv]
// Port-level checks of the wide timer core: bus answers and request flags.
// Assumes one clock domain and a master that offers write address and data together.
module wtb_core_props import wtb_pkg::*; (
  // Clock and reset
  input logic              aclk,
  input logic              aresetn,
  // Register bus
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic              s_axi_wvalid,
  input logic              s_axi_wready,
  input logic [1:0]        s_axi_bresp,
  input logic              s_axi_bvalid,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready,
  // Timer
  input logic [3:0]        timer_requests
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  logic rd_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  // ----
  // Properties
  // ----
  property p_wr_okay;
    wr_go && s_axi_awaddr <= OFS_POWER && s_axi_awaddr[1:0] == 2'h0 |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_wr_okay: assert property (p_wr_okay) else $error("mapped write not okay");
  property p_wr_err;
    wr_go && s_axi_awaddr > OFS_POWER |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
  property p_rd_data;
    rd_go && s_axi_araddr <= OFS_POWER && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read answer not one byte");
  property p_rd_err;
    rd_go && s_axi_araddr > OFS_POWER |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during response");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during response");
  property p_rd_end;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read not closed after handshake");
  property p_req_hold;
    !$rose(s_axi_bvalid) |-> (timer_requests & $past(timer_requests)) == $past(timer_requests);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped without a write");
  c_wr: cover property (wr_go);
  c_ovf: cover property ($rose(timer_requests[0]));
  c_cap: cover property ($rose(timer_requests[3]));
endmodule

bind wtb_core wtb_core_props u_props (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_requests
);

// [wtb_cpu.sv]
// Processor-side model: byte accesses and wide-register sequences on the register bus.
// Assumes bready and rready stay high and every task is entered just after a rising edge.
module wtb_cpu import wtb_pkg::*; (
  // Clock
  input  logic              aclk,
  // Requests
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic              s_axi_awvalid,
  output logic [31:0]       s_axi_wdata,
  output logic              s_axi_wvalid,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic              s_axi_arvalid,
  // Answers
  input  logic              s_axi_awready,
  input  logic              s_axi_wready,
  input  logic              s_axi_bvalid,
  input  logic              s_axi_arready,
  input  logic              s_axi_rvalid,
  input  logic [31:0]       s_axi_rdata,
  input  logic [1:0]        s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] resp;
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
  end
  // ----
  // Access tasks
  // ----
  // Readies come from registers, so the level seen mid-cycle is the one the next edge samples.
  task automatic acc(input bit w, input logic [7:0] a, d, output logic [7:0] q);
    bit pa;
    bit pw;
    bit t;
    bit u;
    pa = 1'b1;
    pw = w;
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wvalid <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
    end
    while (pa || pw) begin
      @(negedge aclk);
      t = w ? s_axi_awready : s_axi_arready;
      u = s_axi_wready;
      @(posedge aclk);
      if (pa && t) begin
        pa = 1'b0;
        if (w) s_axi_awvalid <= 1'b0;
        else s_axi_arvalid <= 1'b0;
      end
      if (pw && u) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge aclk);
      t = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
  endtask
  // Each wide access runs whole inside one call, so nothing can reuse the latch midway.
  task automatic wr16(input logic [7:0] lo, hi, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, hi, v[15:8], q);
    acc(1'b1, lo, v[7:0], q);
  endtask
  task automatic rd16(input logic [7:0] lo, hi, output logic [15:0] v);
    acc(1'b0, lo, 8'h00, v[7:0]);
    acc(1'b0, hi, 8'h00, v[15:8]);
  endtask
endmodule

// [wtb_pkg.sv]
// Constants, field layouts and types for the wide timer with byte-wide access.
// Assumes one system clock and an AXI4-Lite master that keeps 8-bit registers in byte lane 0.
//
// What this block does
// - A count value of zero is the bottom limit.
// - A count value of all ones, 65535, is the maximum.
// - Top comes from maximum, compare A, capture register or a fixed value.
// - With compare A as top in pulse-width mode, channel A drives no pulse.
// - Control register C is a plain 8-bit read/write register; A keeps only bits 2:0 and B bits 5:0.
// - Overflow, compare and capture requests sit in the flag register, each maskable.
// - Clock select picks internal, divided or external edge; none selected stops counting.
// - Each compare value is matched continuously; a match drives its pin and flag.
// - In pulse-width mode, compare values are double buffered against writes at arbitrary moments.
// - A chosen edge on capture pin or comparator copies the count, optionally filtered.
// - Wide registers are 16 bits, moved as two bytes through one shared latch.
// - Writing a low byte loads latch and new byte into the register at once.
// - Reading a count or capture low byte copies that register's high byte into the latch.
// - Compare register reads return both bytes directly, leaving the latch alone.
// - A count write beats any clear or count step in the same cycle.
// - The capture register takes writes only when it is the selected top.
package wtb_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_FLAG   = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_CNT_L  = 8'h14;
  localparam logic [7:0] OFS_CNT_H  = 8'h18;
  localparam logic [7:0] OFS_CMPA_L = 8'h1c;
  localparam logic [7:0] OFS_CMPA_H = 8'h20;
  localparam logic [7:0] OFS_CMPB_L = 8'h24;
  localparam logic [7:0] OFS_CMPB_H = 8'h28;
  localparam logic [7:0] OFS_CAP_L  = 8'h2c;
  localparam logic [7:0] OFS_CAP_H  = 8'h30;
  localparam logic [7:0] OFS_POWER  = 8'h34;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Counter limits and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [1:0] TOP_MAX   = 2'h0;
  localparam logic [1:0] TOP_CMPA  = 2'h1;
  localparam logic [1:0] TOP_CAP   = 2'h2;
  localparam logic [1:0] TOP_FIXED = 2'h3;
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_SYS      = 3'h1;
  localparam logic [2:0] CS_DIV      = 3'h2;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned FLG_OVF  = 0;
  localparam int unsigned FLG_CMPA = 1;
  localparam int unsigned FLG_CMPB = 2;
  localparam int unsigned FLG_CAP  = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] rsv;
    logic       pwm;
    logic [1:0] top_sel;
  } wtb_ctla_t;
  typedef struct packed {
    logic [1:0] rsv;
    logic       noise_en;
    logic       cap_src;
    logic       cap_rise;
    logic [2:0] clk_sel;
  } wtb_ctlb_t;
  typedef enum logic [1:0] {
    WTB_RD_IDLE = 2'b01,
    WTB_RD_BUSY = 2'b10
  } wtb_rd_t;
endpackage
